// ---- rtl/tkirq_pkg.sv ----
// shared constants for the thermal and push button interrupt block
package tkirq_pkg;
	// register index; byte address on the bus is four times the index
	localparam logic [7:0] TEMP_STAT_IDX = 8'h20;
	localparam logic [7:0] TEMP_MASK_IDX = 8'h21;
	localparam logic [7:0] TEMP_SENSE_IDX = 8'h22;
	localparam logic [7:0] KEY_STAT_IDX = 8'h24;
	localparam logic [7:0] KEY_MASK_IDX = 8'h25;
	localparam logic [7:0] KEY_SENSE_IDX = 8'h26;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;
	// bit positions
	localparam int TEMP_LOW_BIT = 0;
	localparam int TEMP_HIGH_BIT = 2;
	localparam int KEY_PUSH_BIT = 0;
	localparam int KEY_HOLD_LSB = 1;
	localparam int HOLD_N = 5;
	// implemented bits; everything else reads zero
	localparam logic [7:0] TEMP_BITS = 8'h05;
	localparam logic [7:0] KEY_BITS = 8'h3F;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] TEMP_MASK_RST = 8'h05;
	localparam logic [7:0] KEY_MASK_RST = 8'h3F;
	// timing
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int TICK_TIME_MS = 1;
	localparam int MS_PER_S = 1000;
	localparam int TICK_CYCLES = TICK_TIME_MS * (CLK_FREQ_HZ / MS_PER_S);
	localparam int HOLD_1S_S = 1;
	localparam int HOLD_2S_S = 2;
	localparam int HOLD_3S_S = 3;
	localparam int HOLD_4S_S = 4;
	localparam int HOLD_8S_S = 8;
	localparam int HOLD_1S_TICKS = HOLD_1S_S * MS_PER_S / TICK_TIME_MS;
	localparam int HOLD_2S_TICKS = HOLD_2S_S * MS_PER_S / TICK_TIME_MS;
	localparam int HOLD_3S_TICKS = HOLD_3S_S * MS_PER_S / TICK_TIME_MS;
	localparam int HOLD_4S_TICKS = HOLD_4S_S * MS_PER_S / TICK_TIME_MS;
	localparam int HOLD_8S_TICKS = HOLD_8S_S * MS_PER_S / TICK_TIME_MS;
	localparam int HOLD_CNT_W = 14;
	// bus handshake states
	typedef enum logic [1:0] {
		TKIRQ_IDLE = 2'b01,
		TKIRQ_ACK = 2'b10
	} tkirq_bus_t;
endpackage

// ---- rtl/tkirq_sync.sv ----
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module tkirq_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tkirq_sync_st_t;

	tkirq_sync_st_t st_reg;
	tkirq_sync_st_t st_next;

	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule

// ---- rtl/tkirq_hold_timer.sv ----
// millisecond hold counter, runs while enabled, saturates
`timescale 1ns/100ps
module tkirq_hold_timer #(
	parameter int TICK_CYCLES = tkirq_pkg::TICK_CYCLES,
	parameter int CNT_W = tkirq_pkg::HOLD_CNT_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic run,
	output logic [CNT_W-1:0] ms_count
);
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] cnt;
	} tkirq_tmr_st_t;

	tkirq_tmr_st_t st_reg;
	tkirq_tmr_st_t st_next;

	always_comb begin
		st_next = st_reg;
		// prescaler restarts on each press so a hold is timed from its start
		if (!run) begin
			st_next.pre = '0;
			st_next.cnt = '0;
		end else if (st_reg.pre == PRE_LAST) begin
			st_next.pre = '0;
			if (st_reg.cnt != '1) begin
				st_next.cnt = st_reg.cnt + CNT_W'(1);
			end
		end else begin
			st_next.pre = st_reg.pre + PRE_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ms_count = st_reg.cnt;
endmodule

// ---- rtl/tkirq_top.sv ----
// thermal crossing and push button interrupt controller, Avalon-MM slave
`timescale 1ns/100ps
module tkirq_top #(
	parameter int TICK_CYCLES = tkirq_pkg::TICK_CYCLES,
	parameter int HOLD_1S_TICKS = tkirq_pkg::HOLD_1S_TICKS,
	parameter int HOLD_2S_TICKS = tkirq_pkg::HOLD_2S_TICKS,
	parameter int HOLD_3S_TICKS = tkirq_pkg::HOLD_3S_TICKS,
	parameter int HOLD_4S_TICKS = tkirq_pkg::HOLD_4S_TICKS,
	parameter int HOLD_8S_TICKS = tkirq_pkg::HOLD_8S_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [tkirq_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic temp_low_cmp,
	input wire logic temp_high_cmp,
	input wire logic power_button_db_n,
	output logic irq_request_n
);
	localparam int CW = tkirq_pkg::HOLD_CNT_W;
	localparam int HN = tkirq_pkg::HOLD_N;

	typedef struct packed {
		tkirq_pkg::tkirq_bus_t bus;
		logic wait_b;
		logic [31:0] rdata;
		logic [7:0] temp_stat;
		logic [7:0] temp_mask;
		logic [7:0] key_stat;
		logic [7:0] key_mask;
		logic [HN-1:0] key_hold;
		logic [1:0] settle;
		logic armed;
		logic low_prev;
		logic high_prev;
		logic push_prev;
		logic irq_n;
	} tkirq_st_t;

	tkirq_st_t st_reg;
	tkirq_st_t st_next;

	logic [2:0] sync_q;
	logic temp_low_lvl;
	logic temp_high_lvl;
	logic pressed;
	logic [CW-1:0] ms_count;
	logic [7:0] reg_idx;
	logic wr_ack;
	logic [7:0] wr_byte;
	logic [7:0] temp_set;
	logic [7:0] key_set;
	logic [HN-1:0] hold_reached;

	tkirq_sync #(
		.W(3)
	) u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.d({temp_low_cmp, temp_high_cmp, ~power_button_db_n}),
		.q(sync_q)
	);

	assign temp_low_lvl = sync_q[2];
	assign temp_high_lvl = sync_q[1];
	// inverted ahead of the flops so their reset value means released
	assign pressed = sync_q[0];

	tkirq_hold_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.CNT_W(CW)
	) u_timer (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.run(pressed),
		.ms_count(ms_count)
	);

	// set wins over a clear arriving in the same cycle
	function automatic logic [7:0] w1c(input logic [7:0] stat, input logic [7:0] clr,
		input logic [7:0] set, input logic [7:0] bits);
		w1c = ((stat & ~clr) | set) & bits;
	endfunction

	function automatic logic reached(input logic [CW-1:0] cnt, input int thr);
		reached = cnt >= CW'(thr);
	endfunction

	function automatic logic [31:0] rd_mux(input logic [7:0] idx, input tkirq_st_t s,
		input logic lo, input logic hi, input logic push);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			tkirq_pkg::TEMP_STAT_IDX: v = s.temp_stat;
			tkirq_pkg::TEMP_MASK_IDX: v = s.temp_mask;
			tkirq_pkg::TEMP_SENSE_IDX: begin
				v[tkirq_pkg::TEMP_LOW_BIT] = lo;
				v[tkirq_pkg::TEMP_HIGH_BIT] = hi;
			end
			tkirq_pkg::KEY_STAT_IDX: v = s.key_stat;
			tkirq_pkg::KEY_MASK_IDX: v = s.key_mask;
			tkirq_pkg::KEY_SENSE_IDX: begin
				v[tkirq_pkg::KEY_PUSH_BIT] = push;
				v[tkirq_pkg::KEY_HOLD_LSB +: HN] = s.key_hold;
			end
			default: v = 8'h00;
		endcase
		rd_mux = {24'h000000, v};
	endfunction

	assign reg_idx = avs_address[tkirq_pkg::IDX_LSB +: 8];
	// write lands on the edge where waitrequest is seen low
	assign wr_ack = (st_reg.bus == tkirq_pkg::TKIRQ_ACK) && avs_write && avs_byteenable[0];
	assign wr_byte = avs_writedata[7:0];

	assign hold_reached = {
		reached(ms_count, HOLD_8S_TICKS),
		reached(ms_count, HOLD_4S_TICKS),
		reached(ms_count, HOLD_3S_TICKS),
		reached(ms_count, HOLD_2S_TICKS),
		reached(ms_count, HOLD_1S_TICKS)
	};

	always_comb begin
		temp_set = 8'h00;
		key_set = 8'h00;
		// armed waits out the synchroniser so a level present at reset is no crossing
		temp_set[tkirq_pkg::TEMP_LOW_BIT] = st_reg.armed && (temp_low_lvl != st_reg.low_prev);
		temp_set[tkirq_pkg::TEMP_HIGH_BIT] = st_reg.armed && (temp_high_lvl != st_reg.high_prev);
		// press and release both count, the debouncer only releases after a press
		key_set[tkirq_pkg::KEY_PUSH_BIT] = st_reg.armed && (pressed != st_reg.push_prev);
		key_set[tkirq_pkg::KEY_HOLD_LSB +: HN] = pressed ? (hold_reached & ~st_reg.key_hold) : '0;
	end

	always_comb begin
		st_next = st_reg;
		st_next.settle = {st_reg.settle[0], 1'b1};
		st_next.armed = st_reg.settle[1];
		st_next.low_prev = temp_low_lvl;
		st_next.high_prev = temp_high_lvl;
		st_next.push_prev = pressed;
		st_next.key_hold = pressed ? (st_reg.key_hold | hold_reached) : '0;
		case (st_reg.bus)
			tkirq_pkg::TKIRQ_IDLE: begin
				st_next.wait_b = 1'b1;
				if (avs_read || avs_write) begin
					st_next.bus = tkirq_pkg::TKIRQ_ACK;
					st_next.wait_b = 1'b0;
					st_next.rdata = avs_read ?
						rd_mux(reg_idx, st_reg, temp_low_lvl, temp_high_lvl, pressed) : 32'h00000000;
				end
			end
			tkirq_pkg::TKIRQ_ACK: begin
				st_next.bus = tkirq_pkg::TKIRQ_IDLE;
				st_next.wait_b = 1'b1;
			end
			default: begin
				st_next.bus = tkirq_pkg::TKIRQ_IDLE;
				st_next.wait_b = 1'b1;
			end
		endcase
		st_next.temp_stat = w1c(st_reg.temp_stat,
			(wr_ack && reg_idx == tkirq_pkg::TEMP_STAT_IDX) ? wr_byte : 8'h00,
			temp_set, tkirq_pkg::TEMP_BITS);
		st_next.key_stat = w1c(st_reg.key_stat,
			(wr_ack && reg_idx == tkirq_pkg::KEY_STAT_IDX) ? wr_byte : 8'h00,
			key_set, tkirq_pkg::KEY_BITS);
		if (wr_ack && reg_idx == tkirq_pkg::TEMP_MASK_IDX) begin
			st_next.temp_mask = wr_byte & tkirq_pkg::TEMP_BITS;
		end
		if (wr_ack && reg_idx == tkirq_pkg::KEY_MASK_IDX) begin
			st_next.key_mask = wr_byte & tkirq_pkg::KEY_BITS;
		end
		// registered from the next status and mask, so the request changes on the same edge as the status bit
		st_next.irq_n = ~(|(st_next.temp_stat & ~st_next.temp_mask) |
			|(st_next.key_stat & ~st_next.key_mask));
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg.bus <= tkirq_pkg::TKIRQ_IDLE;
			st_reg.wait_b <= 1'b1;
			st_reg.rdata <= 32'h00000000;
			st_reg.temp_stat <= tkirq_pkg::STAT_RST;
			st_reg.temp_mask <= tkirq_pkg::TEMP_MASK_RST;
			st_reg.key_stat <= tkirq_pkg::STAT_RST;
			st_reg.key_mask <= tkirq_pkg::KEY_MASK_RST;
			st_reg.key_hold <= '0;
			st_reg.settle <= 2'b00;
			st_reg.armed <= 1'b0;
			st_reg.low_prev <= 1'b0;
			st_reg.high_prev <= 1'b0;
			st_reg.push_prev <= 1'b0;
			st_reg.irq_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.wait_b;
	assign irq_request_n = st_reg.irq_n;

	a_temp_low_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.armed && temp_low_lvl != st_reg.low_prev |=> st_reg.temp_stat[0])
		else $error("low threshold crossing did not set status");

	a_temp_high_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.armed && temp_high_lvl != st_reg.high_prev |=> st_reg.temp_stat[2])
		else $error("high threshold crossing did not set status");

	a_w1c_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_ack && reg_idx == tkirq_pkg::KEY_STAT_IDX && wr_byte[1] && !key_set[1]
		|=> !st_reg.key_stat[1])
		else $error("write one did not clear status");

	a_stat_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.temp_stat[0] && !(wr_ack && reg_idx == tkirq_pkg::TEMP_STAT_IDX && wr_byte[0])
		|=> st_reg.temp_stat[0])
		else $error("status bit dropped without a clear");

	a_irq_unmasked: assert property (@(posedge core_clk) disable iff (!rst_b)
		|(st_reg.key_stat & ~st_reg.key_mask) |-> !irq_request_n)
		else $error("unmasked status did not assert request");

	a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(|(st_reg.temp_stat & ~st_reg.temp_mask)) && !(|(st_reg.key_stat & ~st_reg.key_mask))
		|-> irq_request_n)
		else $error("request asserted with nothing unmasked");

	a_temp_sense_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.bus == tkirq_pkg::TKIRQ_IDLE && avs_read && reg_idx == tkirq_pkg::TEMP_SENSE_IDX
		|=> avs_readdata[0] == $past(temp_low_lvl) && avs_readdata[2] == $past(temp_high_lvl)
		&& !avs_waitrequest)
		else $error("thermal sense read mismatch");

	a_push_event: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.armed && $changed(pressed) |=> st_reg.key_stat[0])
		else $error("button level change did not set push status");

	a_hold_event: assert property (@(posedge core_clk) disable iff (!rst_b)
		pressed && ms_count >= CW'(HOLD_1S_TICKS) && !st_reg.key_hold[0]
		|=> st_reg.key_stat[1] && st_reg.key_hold[0])
		else $error("one second hold missed");

	a_hold_8s: assert property (@(posedge core_clk) disable iff (!rst_b)
		pressed && ms_count < CW'(HOLD_8S_TICKS) |=> !st_reg.key_hold[4] || $past(st_reg.key_hold[4]))
		else $error("eight second hold flagged early");

	a_push_sense_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.bus == tkirq_pkg::TKIRQ_IDLE && avs_read && reg_idx == tkirq_pkg::KEY_SENSE_IDX
		|=> avs_readdata[0] == $past(pressed))
		else $error("push sense read mismatch");

	a_hold_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		!pressed |=> st_reg.key_hold == '0)
		else $error("hold sense survived release");

	a_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st_reg.temp_stat & ~tkirq_pkg::TEMP_BITS) == 8'h00
		&& (st_reg.key_mask & ~tkirq_pkg::KEY_BITS) == 8'h00)
		else $error("unused bit became set");
endmodule

// ---- tb/tkirq_partner.sv ----
// far side model: power button, die temperature comparators, host interrupt input
`timescale 1ns/100ps
module tkirq_partner (
	input wire logic core_clk,
	input wire logic press,
	input wire logic above_low,
	input wire logic above_high,
	input wire logic irq_request_n,
	output logic power_button_db_n,
	output logic temp_low_cmp,
	output logic temp_high_cmp,
	output logic [15:0] irq_low_cycles
);
	initial irq_low_cycles = 16'h0000;
	// idle levels from time zero, released button and cool die
	initial begin
		power_button_db_n = 1'b1;
		temp_low_cmp = 1'b0;
		temp_high_cmp = 1'b0;
	end
	// pins move off the clock grid, as truly asynchronous levels do
	always @(press or above_low or above_high) begin
		power_button_db_n <= #1.3 !press;
		temp_low_cmp <= #2.1 above_low;
		temp_high_cmp <= #0.7 above_high;
	end
	// host samples its level interrupt input each cycle
	always @(posedge core_clk) begin
		if (irq_request_n === 1'b0) begin
			irq_low_cycles <= irq_low_cycles + 16'h0001;
		end
	end
endmodule

// ---- tb/tkirq_top_bench.sv ----
// self-checking bench for the thermal and push button interrupt block
`timescale 1ns/100ps
module tkirq_top_bench;
	localparam int TK = 4;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] be = 4'hF;
	logic press = 1'b0;
	logic lo = 1'b0;
	logic hi = 1'b0;
	logic temp_low_cmp, temp_high_cmp, power_button_db_n, irq_request_n;
	logic [15:0] irq_low_cycles;
	logic [7:0] rd, stat, wm;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #2 core_clk = ~core_clk;
	tkirq_top #(.TICK_CYCLES(TK), .HOLD_1S_TICKS(2), .HOLD_2S_TICKS(4), .HOLD_3S_TICKS(6),
		.HOLD_4S_TICKS(8), .HOLD_8S_TICKS(16)) u_tkirq_top (.core_clk(core_clk),
		.rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.temp_low_cmp(temp_low_cmp), .temp_high_cmp(temp_high_cmp),
		.power_button_db_n(power_button_db_n), .irq_request_n(irq_request_n));
	tkirq_partner u_tkirq_partner (.core_clk(core_clk), .press(press), .above_low(lo),
		.above_high(hi), .irq_request_n(irq_request_n), .power_button_db_n(power_button_db_n),
		.temp_low_cmp(temp_low_cmp), .temp_high_cmp(temp_high_cmp),
		.irq_low_cycles(irq_low_cycles));
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			test_done;
		end
	end
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(input logic exp);
		samples_checked++;
		if (irq_request_n !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t irq got=%h exp=%h", $time, irq_request_n, exp);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] r);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		r = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, rd);
		chk_reg(rd, exp);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, rd);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	function automatic logic [7:0] temp_bits(input logic l, input logic h);
		return {5'h00, h, 1'b0, l};
	endfunction
	initial begin
		void'($urandom(32'h1b55));
		waitc(3);
		rst_b <= 1'b1;
		waitc(1);
		rd_chk(8'h20, 8'h00);
		rd_chk(8'h21, 8'h05);
		rd_chk(8'h25, 8'h3F);
		rd_chk(8'h23, 8'h00);
		chk_irq(1'b1);
		$display("test reset values done");
		stat = 8'h00;
		for (int i = 0; i < 12; i++) begin
			logic nl, nh;
			nl = 1'($urandom);
			nh = 1'($urandom);
			stat = stat | temp_bits(nl ^ lo, nh ^ hi);
			lo <= nl;
			hi <= nh;
			waitc(6);
			rd_chk(8'h22, temp_bits(nl, nh));
			rd_chk(8'h20, stat);
			wm = 8'($urandom);
			wr(8'h20, wm);
			stat = stat & ~wm & 8'h05;
			rd_chk(8'h20, stat);
			chk_irq(1'b1);
		end
		$display("test thermal crossings done");
		wr(8'h20, 8'hFF);
		lo <= !lo;
		wr(8'h21, 8'hFA);
		rd_chk(8'h21, 8'h00);
		waitc(3);
		chk_irq(1'b0);
		wr(8'h21, 8'h05);
		waitc(2);
		chk_irq(1'b1);
		be <= 4'hE;
		wr(8'h21, 8'h00);
		be <= 4'hF;
		rd_chk(8'h21, 8'h05);
		wr(8'h20, 8'h01);
		chk_reg(8'(irq_low_cycles != 16'h0), 8'h01);
		$display("test thermal interrupt done");
		press <= 1'b1;
		waitc(14);
		rd_chk(8'h24, 8'h03);
		rd_chk(8'h26, 8'h03);
		waitc(16 * TK + 8);
		rd_chk(8'h24, 8'h3F);
		rd_chk(8'h26, 8'h3F);
		wr(8'h24, 8'h01);
		rd_chk(8'h24, 8'h3E);
		press <= 1'b0;
		waitc(6);
		rd_chk(8'h26, 8'h00);
		rd_chk(8'h24, 8'h3F);
		wr(8'h25, 8'h1F);
		waitc(2);
		chk_irq(1'b0);
		wr(8'h24, 8'h20);
		waitc(2);
		chk_irq(1'b1);
		rd_chk(8'h24, 8'h1F);
		$display("test push button done");
		test_done;
	end
endmodule
